/* File: verilog/nic_pkg.sv */
// Shared constants and carrier types for the nested interrupt context stack.
package nic_pkg;
   localparam int BANK_W = 4;
   localparam int PSW_W = 4;
   localparam int ADDR_W = 14;
   localparam int SRC_N = 4;
   localparam int ISTK_N = 2;
   localparam int ASTK_N = 7;
   localparam int DEPTH_W = 3;
   localparam int RF_W = 7;
   // Source index order is also the fixed hardware priority, 0 highest.
   localparam int SRC_REMOTE = 0;
   localparam int SRC_VSYNC = 1;
   localparam int SRC_TIMER = 2;
   localparam int SRC_SERIAL = 3;
   localparam logic [RF_W-1:0] RF_MEM_BASE = 7'h40;
   localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;
   localparam logic [PSW_W-1:0] PSW_RESET = 4'h0;
   localparam logic [SRC_N-1:0] ENABLE_RESET = 4'h0;
   localparam logic [DEPTH_W-1:0] ASTK_FULL = 3'h7;
   localparam logic [1:0] ISTK_FULL = 2'h2;

   typedef struct packed {
      logic [BANK_W-1:0] bank;
      logic [PSW_W-1:0] psw;
   } nic_ctx_t;

   typedef struct packed {
      logic valid;
      logic toMemory;
      logic write;
      logic [BANK_W+5:0] addr;
   } nic_rf_t;

   typedef struct packed {
      nic_ctx_t ctx;
      nic_ctx_t [ISTK_N-1:0] ctxStack;
      logic [1:0] ctxCount;
      logic [ASTK_N-1:0][ADDR_W-1:0] addrStack;
      logic [DEPTH_W-1:0] addrDepth;
      logic addrOverflow;
      logic [SRC_N-1:0] pending;
      logic [SRC_N-1:0] enable;
      logic globalEnable;
      logic enableDeferred;
      logic irqTaken;
      logic [1:0] irqSource;
      logic [ADDR_W-1:0] returnAddr;
      logic returnValid;
      nic_rf_t rf;
   } nic_state_t;
endpackage

/* File: verilog/nic_context_stack.sv */
// Interrupt acceptance, context stacks and register-file window for a 4-bit CPU.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Accept pushes bank and status, clears both.
// - Context stack holds exactly two entries.
// - Push when full drops the oldest entry.
// - Interrupt return equals subroutine return plus context pop.
// - Accept pushes return address on seven-entry stack.
// - Calls share the same seven-entry address stack.
// - Four sources: remote, timer, vsync, serial.
// - Handler starts with data memory bank zero.
// - Per-source enable flags, readable and writable.
// - Global enable op unmasks enabled sources.
// - Fixed priority order, software masks via enables.
// - Register file reaches memory at 40H upward.
// - Enable op takes effect after following instruction.
module nic_context_stack
   import nic_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Request events from the sources, one-cycle pulses
   input wire logic remoteControlInput,
   input wire logic vsyncEvent,
   input wire logic timerEvent,
   input wire logic serialDoneEvent,
   // Instruction sequencer strobes
   input wire logic instrDone,
   input wire logic callOp,
   input wire logic subroutine_return_op,
   input wire logic return_from_interrupt_op,
   input wire logic global_irq_enable_op,
   input wire logic globalIrqDisableOp,
   input wire logic [ADDR_W-1:0] nextPc,
   // Software writes of the context and enable flags
   input wire logic bankWrite,
   input wire logic [BANK_W-1:0] bankData,
   input wire logic pswWrite,
   input wire logic [PSW_W-1:0] pswData,
   input wire logic enableWrite,
   input wire logic [SRC_N-1:0] enableData,
   input wire logic pendingClear,
   input wire logic [SRC_N-1:0] pendingClearMask,
   // Register file access by the register_file_read_op and register_file_write_op ops
   input wire logic register_file_read_op,
   input wire logic register_file_write_op,
   input wire logic [RF_W-1:0] rfAddr,
   // Context and flag state
   output logic [BANK_W-1:0] bank,
   output logic [PSW_W-1:0] program_status_word,
   output logic [SRC_N-1:0] irqEnable,
   output logic [SRC_N-1:0] irqPending,
   output logic globalEnable,
   // Acceptance and return
   output logic irqTaken,
   output logic [1:0] irqSource,
   output logic [ADDR_W-1:0] returnAddr,
   output logic returnValid,
   output logic [DEPTH_W-1:0] addrDepth,
   output logic addrOverflow,
   output logic [1:0] ctxCount,
   // Register file routing
   output nic_rf_t rfAccess
);

   ////////////////////////////////////////////////////////////////////////////
   nic_state_t state;
   nic_state_t next_state;
   logic [SRC_N-1:0] requests;
   logic [SRC_N-1:0] eligible;
   logic [SRC_N-1:0] winnerMask;
   logic [1:0] winner;
   logic accept;
   logic anyReturn;

   assign requests = {serialDoneEvent, timerEvent, vsyncEvent, remoteControlInput};
   assign eligible = state.pending & state.enable;
   assign anyReturn = subroutine_return_op | return_from_interrupt_op;

   genvar gi;
   generate
      for (gi = 0; gi < SRC_N; gi++) begin : gPrio
         if (gi == 0) begin : gTop
            assign winnerMask[gi] = eligible[gi];
         end else begin : gRest
            assign winnerMask[gi] = eligible[gi] & ~|eligible[gi-1:0];
         end
      end
   endgenerate

   always_comb begin
      winner = 2'h0;
      for (int i = SRC_N - 1; i >= 0; i--) begin
         if (winnerMask[i]) begin
            winner = i[1:0];
         end
      end
   end

   // only while global enable is set
   // Accepting only at an instruction boundary without a stack op avoids two pushes at once.
   assign accept = instrDone & state.globalEnable & ~state.enableDeferred & (|eligible)
                   & ~callOp & ~anyReturn;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      next_state.irqTaken = 1'b0;
      next_state.returnValid = 1'b0;

      // Software context and flag writes.
      if (bankWrite) begin
         next_state.ctx.bank = bankData;
      end
      if (pswWrite) begin
         next_state.ctx.psw = pswData;
      end
      if (enableWrite) begin
         next_state.enable = enableData;
      end
      if (pendingClear) begin
         next_state.pending = state.pending & ~pendingClearMask;
      end

      // Global enable control.
      if (globalIrqDisableOp) begin
         next_state.globalEnable = 1'b0;
         next_state.enableDeferred = 1'b0;
      end else if (global_irq_enable_op) begin
         next_state.enableDeferred = 1'b1;
      end else if (state.enableDeferred && instrDone) begin
         next_state.enableDeferred = 1'b0;
         next_state.globalEnable = 1'b1;
      end

      if (callOp || accept) begin
         if (state.addrDepth == ASTK_FULL) begin
            next_state.addrOverflow = 1'b1;
         end else begin
            next_state.addrStack[state.addrDepth] = nextPc;
            next_state.addrDepth = state.addrDepth + 3'h1;
         end
      end else if (anyReturn) begin
         // both returns pop the address stack
         if (state.addrDepth != 3'h0) begin
            next_state.returnAddr = state.addrStack[state.addrDepth - 3'h1];
            next_state.addrDepth = state.addrDepth - 3'h1;
         end
         next_state.returnValid = 1'b1;
      end

      if (accept) begin
         next_state.irqTaken = 1'b1;
         next_state.irqSource = winner;
         next_state.pending[winner] = 1'b0;
         next_state.globalEnable = 1'b0;
         next_state.enableDeferred = 1'b0;
         next_state.ctxStack[1] = state.ctxStack[0];
         next_state.ctxStack[0] = state.ctx;
         next_state.ctx.bank = BANK_RESET;
         next_state.ctx.psw = PSW_RESET;
         if (state.ctxCount != ISTK_FULL) begin
            next_state.ctxCount = state.ctxCount + 2'h1;
         end
      end else if (return_from_interrupt_op) begin
         next_state.ctx = state.ctxStack[0];
         // The deeper entry is kept, so an over-deep unwind reads a stale context.
         next_state.ctxStack[0] = state.ctxStack[1];
         if (state.ctxCount != 2'h0) begin
            next_state.ctxCount = state.ctxCount - 2'h1;
         end
      end

      // Set wins over any clear in the same cycle.
      next_state.pending = next_state.pending | requests;

      // memory overlay at 40H and above
      next_state.rf.valid = register_file_read_op | register_file_write_op;
      next_state.rf.write = register_file_write_op;
      next_state.rf.toMemory = (rfAddr >= RF_MEM_BASE);
      next_state.rf.addr = {next_state.ctx.bank, rfAddr[5:0]};
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= '0;
         state.ctx.bank <= BANK_RESET;
         state.ctx.psw <= PSW_RESET;
         state.enable <= ENABLE_RESET;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign bank = state.ctx.bank;
   assign program_status_word = state.ctx.psw;
   assign irqEnable = state.enable;
   assign irqPending = state.pending;
   assign globalEnable = state.globalEnable;
   assign irqTaken = state.irqTaken;
   assign irqSource = state.irqSource;
   assign returnAddr = state.returnAddr;
   assign returnValid = state.returnValid;
   assign addrDepth = state.addrDepth;
   assign addrOverflow = state.addrOverflow;
   assign ctxCount = state.ctxCount;
   assign rfAccess = state.rf;

endmodule
`default_nettype wire

/* File: verification/nic_context_props.sv */
// Concurrent checks on the ports of the context stack.
`timescale 1ns/1ns
`default_nettype none
module nic_context_props
   import nic_pkg::*;
(
   // Clock, reset and strobes
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic instrDone,
   input wire logic callOp,
   input wire logic subroutine_return_op,
   input wire logic return_from_interrupt_op,
   input wire logic global_irq_enable_op,
   input wire logic register_file_read_op,
   input wire logic [RF_W-1:0] rfAddr,
   // Watched outputs
   input wire logic [BANK_W-1:0] bank,
   input wire logic [PSW_W-1:0] program_status_word,
   input wire logic [SRC_N-1:0] irqEnable,
   input wire logic globalEnable,
   input wire logic irqTaken,
   input wire logic [1:0] irqSource,
   input wire logic returnValid,
   input wire logic [DEPTH_W-1:0] addrDepth,
   input wire logic [1:0] ctxCount,
   input wire nic_rf_t rfAccess
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   sequence s_ret;
      (subroutine_return_op || return_from_interrupt_op) && !callOp;
   endsequence
   sequence s_rd;
      register_file_read_op ##1 rfAccess.valid;
   endsequence
   a_accept_clears_ctx: assert property (irqTaken |-> bank == 4'h0 && program_status_word == 4'h0)
      else $error("context not cleared on accept");
   a_accept_drops_enable: assert property (irqTaken |-> !globalEnable)
      else $error("global enable kept on accept");
   a_accept_needs_enable: assert property (irqTaken |-> $past(globalEnable) && $past(instrDone))
      else $error("accept while inhibited");
   a_source_is_enabled: assert property (irqTaken |-> (($past(irqEnable) >> irqSource) & 4'h1) != 4'h0)
      else $error("masked source accepted");
   a_ctx_push_cap: assert property (irqTaken |-> ctxCount == (($past(ctxCount) == ISTK_FULL) ? ISTK_FULL : $past(ctxCount) + 2'h1))
      else $error("context count wrong");
   a_addr_push_one: assert property (irqTaken && $past(addrDepth) != ASTK_FULL |-> addrDepth == $past(addrDepth) + 3'h1)
      else $error("return address not pushed");
   a_return_answers: assert property (s_ret |=> returnValid)
      else $error("no return answer");
   a_enable_deferred: assert property ($rose(globalEnable) |-> $past(instrDone) && !$past(global_irq_enable_op))
      else $error("enable not deferred");
   a_rf_window_map: assert property (s_rd |-> rfAccess.toMemory == ($past(rfAddr) >= RF_MEM_BASE) && rfAccess.addr[5:0] == $past(rfAddr[5:0]))
      else $error("register file routing wrong");
endmodule
bind nic_context_stack nic_context_props u_props (.*);
`default_nettype wire

/* File: verification/nic_src_model.sv */
// Edge-detected request sources feeding the four event inputs.
`timescale 1ns/1ns
`default_nettype none
module nic_src_model
   import nic_pkg::*;
(
   // Clock and request levels
   input wire logic ref_clk,
   input wire logic [SRC_N-1:0] fire,
   // Event pulses: remote, vsync, timer, serial
   output logic [SRC_N-1:0] evt
);
   logic [SRC_N-1:0] last = 4'h0;
   initial evt = 4'h0;
   // four request sources
   // A held level gives one pulse only, as a real edge detector does.
   always @(negedge ref_clk) begin
      evt <= fire & ~last;
      last <= fire;
   end
endmodule
`default_nettype wire

/* File: verification/nested_interrupt_context_stack_test.sv */
// Self-checking bench for the nested interrupt context stack.
`timescale 1ns/1ns
`default_nettype none
module nested_interrupt_context_stack_test
   import nic_pkg::*;
;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [4:0] seq = 5'h00;
   logic [1:0] rfOp = 2'h0;
   logic [7:0] ctxIn = 8'h00;
   logic ctxWr = 1'b0;
   logic [SRC_N-1:0] enIn = 4'h0;
   logic [SRC_N-1:0] fire = 4'h0;
   logic [ADDR_W-1:0] nextPc = 14'h0000;
   logic [RF_W-1:0] rfAddr = 7'h00;
   wire [SRC_N-1:0] evt;
   logic [BANK_W-1:0] bank;
   logic [PSW_W-1:0] psw;
   logic [SRC_N-1:0] irqEnable, irqPending;
   logic globalEnable, irqTaken, returnValid, addrOverflow;
   logic [1:0] irqSource, ctxCount;
   logic [ADDR_W-1:0] returnAddr;
   logic [DEPTH_W-1:0] addrDepth;
   nic_rf_t rfAccess;
   int mismatches = 0;
   int tests_run = 0;
   logic [ADDR_W-1:0] pcs [8];
   logic [7:0] ctxs [3];
   ////////////////////////////////////////
   nic_src_model src (.ref_clk(ref_clk), .fire(fire), .evt(evt));
   nic_context_stack dut (.ref_clk(ref_clk), .reset(reset), .remoteControlInput(evt[0]),
      .vsyncEvent(evt[1]), .timerEvent(evt[2]), .serialDoneEvent(evt[3]), .instrDone(seq[4]),
      .callOp(seq[3]), .subroutine_return_op(seq[2]), .return_from_interrupt_op(seq[1]),
      .global_irq_enable_op(seq[0]), .globalIrqDisableOp(1'b0), .nextPc(nextPc),
      .bankWrite(ctxWr), .bankData(ctxIn[7:4]), .pswWrite(ctxWr), .pswData(ctxIn[3:0]),
      .enableWrite(ctxWr), .enableData(enIn), .pendingClear(1'b0), .pendingClearMask(4'h0),
      .register_file_read_op(rfOp[0]), .register_file_write_op(rfOp[1]), .rfAddr(rfAddr),
      .bank(bank), .program_status_word(psw), .irqEnable(irqEnable), .irqPending(irqPending),
      .globalEnable(globalEnable), .irqTaken(irqTaken), .irqSource(irqSource),
      .returnAddr(returnAddr), .returnValid(returnValid), .addrDepth(addrDepth),
      .addrOverflow(addrOverflow), .ctxCount(ctxCount), .rfAccess(rfAccess));
   always #25 ref_clk = ~ref_clk;
   ////////////////////////////////////////
   function automatic logic [1:0] win(input logic [3:0] m);
      win = 2'h0;
      for (int i = 3; i >= 0; i--)
         if (m[i])
            win = i[1:0];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [4:0] s);
      @(negedge ref_clk);
      seq = s;
      @(negedge ref_clk);
      seq = 5'h00;
   endtask
   task automatic setctx(input logic [7:0] v, input logic [3:0] en);
      @(negedge ref_clk);
      ctxIn = v;
      enIn = en;
      ctxWr = 1'b1;
      @(negedge ref_clk);
      ctxWr = 1'b0;
   endtask
   task automatic take(input logic [ADDR_W-1:0] pc, input logic [3:0] m, input logic [2:0] n);
      op(5'h11);
      chk(globalEnable, 1'b0);
      op(5'h10);
      chk(globalEnable, 1'b1);
      nextPc = pc;
      op(5'h10);
      chk({irqTaken, irqSource, bank, psw, globalEnable, ctxCount, addrDepth},
         {1'b1, win(m), 8'h00, 1'b0, (n > 3'h2) ? 2'h2 : n[1:0], n});
   endtask
   task automatic close_out;
      if (mismatches == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      void'($urandom(32'h37226b1c));
      for (int i = 0; i < 3; i++) begin
         ctxs[i] = 8'($urandom);
         pcs[i] = 14'($urandom);
      end
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      chk({bank, psw, irqEnable, irqPending, globalEnable, addrDepth, ctxCount}, 32'h0);
      fire = 4'hf;
      setctx(ctxs[0], 4'hf);
      op(5'h10);
      chk({irqTaken, irqPending, irqEnable}, 9'h0ff);
      take(pcs[0], 4'hf, 3'h1);
      // Software priority: mask the remote source inside the first handler.
      setctx(ctxs[1], 4'he);
      take(pcs[1], 4'he, 3'h2);
      setctx(ctxs[2], 4'he);
      take(pcs[2], 4'hc, 3'h3);
      for (int i = 2; i >= 0; i--) begin
         op(5'h12);
         chk({returnValid, returnAddr, bank, psw}, {1'b1, pcs[i], ctxs[(i == 0) ? 1 : i]});
      end
      for (int i = 0; i < 8; i++) begin
         pcs[i] = 14'($urandom);
         nextPc = pcs[i];
         op(5'h08);
      end
      chk({addrOverflow, addrDepth}, {1'b1, ASTK_FULL});
      for (int i = 6; i >= 0; i--) begin
         op(5'h04);
         chk(returnAddr, pcs[i]);
      end
      setctx(8'h5a, 4'he);
      for (int i = 0; i < 6; i++) begin
         @(negedge ref_clk);
         rfAddr = (i < 2) ? 7'h3f + i[6:0] : 7'($urandom);
         rfOp = {i[0], ~i[0]};
         @(negedge ref_clk);
         rfOp = 2'h0;
         chk(rfAccess, {1'b1, rfAddr >= RF_MEM_BASE, i[0], 4'h5, rfAddr[5:0]});
      end
      pcs[0] = 14'($urandom);
      nextPc = pcs[0];
      op(5'h08);
      setctx(8'h00, 4'he);
      op(5'h14);
      chk({returnValid, returnAddr, bank, psw}, {1'b1, pcs[0], 8'h00});
      close_out();
   end
   initial begin
      #(50 * 2000);
      mismatches++;
      close_out();
   end
endmodule
`default_nettype wire
